// File: common/tmc_defines.vh
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// Serial access format
`define TMC_ADDR_BITS    4
`define TMC_HDR_LAST     6'h04
`define TMC_REG_BITS     6'h20

// Register addresses on the serial port
`define TMC_ADDR_MAIN    4'h4
`define TMC_ADDR_RESET   4'hB

// Main control register reset value and writable bits
`define TMC_MC_RESET     32'h10000270
`define TMC_MC_WMASK     32'hFFFFFBF2

// Main control field positions
`define TMC_POWER        31
`define TMC_DIR          30
`define TMC_RCLK         29
`define TMC_TRANSMIT_ON_LOCK       28
`define TMC_AMP          27
`define TMC_WAKE         26
`define TMC_GAIN         25
`define TMC_MEAS         24
`define TMC_THR_HI       23
`define TMC_THR_LO       18
`define TMC_HYS_HI       17
`define TMC_HYS_LO       15
`define TMC_LVL_HI       14
`define TMC_LVL_LO       12
`define TMC_TXPAIR       11
`define TMC_RXSEL_HI     9
`define TMC_RXSEL_LO     8
`define TMC_XTAL         7
`define TMC_DRANGE       6
`define TMC_POL          5
`define TMC_SLREF        4
`define TMC_OFFS         1

// Shared converter routing codes
`define TMC_ADC_STRENGTH 2'h0
`define TMC_ADC_SUPPLY   2'h1
`define TMC_ADC_DISC     2'h2

`endif

// File: design/tmc_sync2.v
`timescale 1ns/1ps

module tmc_sync2 #(
    parameter             WIDTH     = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input  wire             clock_i,
    input  wire             sys_rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// File: design/tmc_main_control.v
`timescale 1ns/1ps
`include "tmc_defines.vh"
// Functional notes
// - Power bit 0 keeps all but the serial port off; 1 activates device. Code leaves wake-up enable ungated by power.
// - Direction bit 0 selects receive, 1 selects transmit; resets to 0.
// - Clock-recovery bit 0 leaves recovered clock idle, 1 enables it.
// - Transmit-on-lock 1 transmits only while synthesizer locked; 0 ignores lock.
// - Amplifier on only when its bit and the power bit are both 1.
// - Wake-up bit 0 disables wake-up; 1 enables it as configured.
// - Measure bit routes converter to strength (0) or supply (1) result.
// - Data valid at strength >= threshold+hysteresis; inhibited below threshold-hysteresis.
// - Between the two levels the previous validation state is kept.
// - Output power field 000 is minimum level, 111 maximum; resets 000.
// - Transmit pair bit selects frequency registers zero/one or two/three.
// - Receive field 00..11 selects frequency register zero..three; resets 10.
// - Crystal bit 0 selects 10.245 MHz, 1 selects 20.945 MHz.
// - Discriminator range 0 is narrow, 1 standard; resets to 1.
// - Slicer reference 0 uses filter pin, 1 internal level; resets 1.
// - Offset bit 0 measures supply, 1 discriminator DC level; resets 0.
// - During supply measurement strength is frozen at its last value.
// - No supply result is taken while powered down.

module tmc_main_control (
    input  wire        clock_i,
    input  wire        sys_rst_i,
    input  wire        sle_i,
    input  wire        sck_i,
    input  wire        sdata_i,
    output reg         sdata_o,
    output reg         sdata_oe_o,
    input  wire        synth_lock_flag_i,
    input  wire        rx_data_i,
    input  wire        adc_valid_i,
    input  wire [5:0]  adc_value_i,
    output reg         device_active_o,
    output reg         rx_active_o,
    output reg         tx_active_o,
    output reg         amplifier_active_o,
    output reg  [2:0]  output_power_level_o,
    output reg         recovered_clock_enable_o,
    output reg         wakeup_enable_o,
    output reg         input_gain_select_o,
    output reg  [1:0]  adc_select_o,
    output reg  [1:0]  tx_freq_reg_low_o,
    output reg  [1:0]  tx_freq_reg_high_o,
    output reg  [1:0]  rx_freq_reg_o,
    output reg         crystal_select_o,
    output reg         discriminator_range_o,
    output reg         data_polarity_o,
    output reg         slicer_reference_select_o,
    output reg         data_valid_o,
    output reg         demodulated_data_out_o,
    output reg  [5:0]  measured_strength_o,
    output reg  [5:0]  supply_level_o,
    output reg  [5:0]  discriminator_level_o,
    output reg  [31:0] main_control_o
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_HDR  = 5'h02;
    localparam [4:0] ST_WR   = 5'h04;
    localparam [4:0] ST_RD   = 5'h08;
    localparam [4:0] ST_SKIP = 5'h10;

    wire [4:0] pins_s;
    wire       sle_s;
    wire       sck_s;
    wire       sd_s;
    wire       lock_s;
    wire       rxd_s;

    reg        sle_p_q;
    reg        sck_p_q;
    reg  [4:0] state_q;
    reg  [4:0] hdr_q;
    reg  [5:0] cnt_q;
    reg [31:0] shadow_q;
    reg [31:0] snap_q;
    reg        wr_q;
    reg        srst_q;
    reg [31:0] mc_q;

    wire sle_rise;
    wire sle_fall;
    wire sck_rise;
    wire sck_fall;
    wire [3:0] addr;
    wire       hdr_wr;
    wire       rd_hit;

    // Register bit index for the n-th serial data bit, MSB first
    function [4:0] msb_idx;
        input [5:0] c;
        begin
            msb_idx = 5'h1F - c[4:0];
        end
    endfunction

    // Enable stage resets to its idle high level so no false frame edge follows reset
    tmc_sync2 #(
        .WIDTH     (5),
        .RESET_VAL (5'h10)
    ) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({sle_i, sck_i, sdata_i, synth_lock_flag_i, rx_data_i}),
        .sync_o    (pins_s)
    );

    assign sle_s  = pins_s[4];
    assign sck_s  = pins_s[3];
    assign sd_s   = pins_s[2];
    assign lock_s = pins_s[1];
    assign rxd_s  = pins_s[0];

    assign sle_rise = sle_s & ~sle_p_q;
    assign sle_fall = ~sle_s & sle_p_q;
    assign sck_rise = sck_s & ~sck_p_q;
    assign sck_fall = ~sck_s & sck_p_q;
    assign addr     = hdr_q[4:1];
    assign hdr_wr   = hdr_q[0];
    assign rd_hit   = (addr == `TMC_ADDR_MAIN);

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sle_p_q <= 1'b1;
            sck_p_q <= 1'b0;
        end else begin
            sle_p_q <= sle_s;
            sck_p_q <= sck_s;
        end
    end

    // Serial port stays alive in power-down so software can wake the device
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q    <= ST_IDLE;
            hdr_q      <= 5'h00;
            cnt_q      <= 6'h00;
            shadow_q   <= 32'h00000000;
            snap_q     <= 32'h00000000;
            wr_q       <= 1'b0;
            srst_q     <= 1'b0;
            sdata_o    <= 1'b0;
            sdata_oe_o <= 1'b0;
        end else begin
            wr_q   <= 1'b0;
            srst_q <= 1'b0;
            if (sle_rise) begin
                state_q    <= ST_IDLE;
                sdata_o    <= 1'b0;
                sdata_oe_o <= 1'b0;
                if ((state_q == ST_WR) && (cnt_q != 6'h00) && rd_hit) begin
                    wr_q <= 1'b1;
                end
                if (((state_q == ST_WR) || (state_q == ST_SKIP)) && (addr == `TMC_ADDR_RESET)) begin
                    srst_q <= 1'b1;
                end
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (sle_fall) begin
                            state_q <= ST_HDR;
                            cnt_q   <= 6'h00;
                        end
                    end
                    ST_HDR: begin
                        if (sck_rise) begin
                            hdr_q <= {hdr_q[3:0], sd_s};
                            cnt_q <= cnt_q + 6'h01;
                            if (cnt_q == `TMC_HDR_LAST) begin
                                cnt_q    <= 6'h00;
                                shadow_q <= mc_q;
                                snap_q   <= mc_q;
                                state_q  <= sd_s ? ST_WR : ST_RD;
                            end
                        end
                    end
                    ST_WR: begin
                        if (sck_rise) begin
                            if (cnt_q == `TMC_REG_BITS) begin
                                // Extra bit commits at once; the rest is ignored
                                wr_q    <= rd_hit;
                                state_q <= ST_SKIP;
                            end else begin
                                // Unsent low bits keep their old value
                                shadow_q[msb_idx(cnt_q)] <= sd_s;
                                cnt_q <= cnt_q + 6'h01;
                            end
                        end
                    end
                    ST_RD: begin
                        if (sck_fall) begin
                            sdata_oe_o <= 1'b1;
                            if (cnt_q < `TMC_REG_BITS) begin
                                sdata_o <= rd_hit ? snap_q[msb_idx(cnt_q)] : 1'b1;
                                cnt_q   <= cnt_q + 6'h01;
                            end else begin
                                sdata_o <= 1'b0;
                            end
                        end
                    end
                    ST_SKIP: begin
                        state_q <= ST_SKIP;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Reserved bits never store, so they read back as zero
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mc_q <= `TMC_MC_RESET;
        end else if (srst_q) begin
            mc_q <= `TMC_MC_RESET;
        end else if (wr_q) begin
            mc_q <= shadow_q & `TMC_MC_WMASK;
        end
    end

    wire       pwr      = mc_q[`TMC_POWER];
    wire       dir_tx   = mc_q[`TMC_DIR];
    wire [5:0] thr      = mc_q[`TMC_THR_HI:`TMC_THR_LO];
    wire [2:0] hys      = mc_q[`TMC_HYS_HI:`TMC_HYS_LO];
    wire [6:0] hi_level = {1'b0, thr} + {4'h0, hys};
    wire [6:0] meas_hys = {1'b0, adc_value_i} + {4'h0, hys};
    wire [1:0] adc_sel  = ~mc_q[`TMC_MEAS] ? `TMC_ADC_STRENGTH :
                          (mc_q[`TMC_OFFS] ? `TMC_ADC_DISC : `TMC_ADC_SUPPLY);

    // Decoded controls; power-down forces the analog blocks off
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            device_active_o           <= 1'b0;
            rx_active_o               <= 1'b0;
            tx_active_o               <= 1'b0;
            amplifier_active_o        <= 1'b0;
            output_power_level_o      <= 3'h0;
            recovered_clock_enable_o  <= 1'b0;
            wakeup_enable_o           <= 1'b0;
            input_gain_select_o       <= 1'b0;
            adc_select_o              <= `TMC_ADC_STRENGTH;
            tx_freq_reg_low_o         <= 2'h0;
            tx_freq_reg_high_o        <= 2'h1;
            rx_freq_reg_o             <= 2'h2;
            crystal_select_o          <= 1'b0;
            discriminator_range_o     <= 1'b1;
            data_polarity_o           <= 1'b1;
            slicer_reference_select_o <= 1'b1;
            main_control_o            <= `TMC_MC_RESET;
        end else begin
            device_active_o           <= pwr;
            rx_active_o               <= pwr & ~dir_tx;
            tx_active_o               <= pwr & dir_tx & (~mc_q[`TMC_TRANSMIT_ON_LOCK] | lock_s);
            amplifier_active_o        <= pwr & mc_q[`TMC_AMP];
            output_power_level_o      <= mc_q[`TMC_LVL_HI:`TMC_LVL_LO];
            recovered_clock_enable_o  <= pwr & mc_q[`TMC_RCLK];
            wakeup_enable_o           <= mc_q[`TMC_WAKE];
            input_gain_select_o       <= mc_q[`TMC_GAIN];
            adc_select_o              <= adc_sel;
            tx_freq_reg_low_o         <= {mc_q[`TMC_TXPAIR], 1'b0};
            tx_freq_reg_high_o        <= {mc_q[`TMC_TXPAIR], 1'b1};
            rx_freq_reg_o             <= mc_q[`TMC_RXSEL_HI:`TMC_RXSEL_LO];
            crystal_select_o          <= mc_q[`TMC_XTAL];
            discriminator_range_o     <= mc_q[`TMC_DRANGE];
            data_polarity_o           <= mc_q[`TMC_POL];
            slicer_reference_select_o <= mc_q[`TMC_SLREF];
            main_control_o            <= mc_q;
        end
    end

    // Converter results; nothing is taken while powered down
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            measured_strength_o   <= 6'h00;
            supply_level_o        <= 6'h00;
            discriminator_level_o <= 6'h00;
            data_valid_o          <= 1'b0;
        end else if (srst_q || (pwr && !device_active_o) || !pwr) begin
            // Results survive power-down, validation does not
            data_valid_o <= 1'b0;
            if (srst_q) begin
                measured_strength_o   <= 6'h00;
                supply_level_o        <= 6'h00;
                discriminator_level_o <= 6'h00;
            end
        end else if (adc_valid_i) begin
            case (adc_sel)
                `TMC_ADC_STRENGTH: begin
                    measured_strength_o <= adc_value_i;
                    if ({1'b0, adc_value_i} >= hi_level) begin
                        data_valid_o <= 1'b1;
                    end else if (meas_hys < {1'b0, thr}) begin
                        data_valid_o <= 1'b0;
                    end
                end
                `TMC_ADC_SUPPLY: begin
                    supply_level_o <= adc_value_i;
                end
                `TMC_ADC_DISC: begin
                    discriminator_level_o <= adc_value_i;
                end
                default: begin
                    supply_level_o <= supply_level_o;
                end
            endcase
        end
    end

    // Inhibited data reads as zero so the host sees no noise bits
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            demodulated_data_out_o <= 1'b0;
        end else begin
            demodulated_data_out_o <= data_valid_o & pwr & ~dir_tx &
                                      (mc_q[`TMC_POL] ? rxd_s : ~rxd_s);
        end
    end

endmodule

// File: sim/tmc_mc_properties.sv
`timescale 1ns/1ps
module tmc_mc_properties (
    input wire        clock_i,
    input wire        sys_rst_i,
    input wire        synth_lock_flag_i,
    input wire        adc_valid_i,
    input wire [5:0]  adc_value_i,
    input wire        device_active_o,
    input wire        rx_active_o,
    input wire        tx_active_o,
    input wire        amplifier_active_o,
    input wire [2:0]  output_power_level_o,
    input wire [1:0]  adc_select_o,
    input wire [1:0]  tx_freq_reg_low_o,
    input wire [1:0]  rx_freq_reg_o,
    input wire        data_valid_o,
    input wire [5:0]  measured_strength_o,
    input wire [5:0]  supply_level_o,
    input wire [31:0] main_control_o
);
    default clocking dcb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    wire [31:0] mc     = main_control_o;
    wire [5:0]  thr    = mc[23:18];
    wire [6:0]  hi_lvl = {1'b0, thr} + {4'h0, mc[17:15]};
    wire [6:0]  lo_sum = {1'b0, adc_value_i} + {4'h0, mc[17:15]};
    // Lock is synchronised then registered, so four low cycles are needed; the sequence waits for five
    sequence lock_lost_s;
        (mc[28] && !synth_lock_flag_i) [*5];
    endsequence
    sequence off_supply_s;
        (!device_active_o && adc_select_o == 2'h1) [*3];
    endsequence
    a_amp_needs_power: assert property (amplifier_active_o == (mc[31] && mc[27]))
        else $error("amplifier state differs from power and enable bits");
    a_dir_select: assert property (rx_active_o == (mc[31] && !mc[30]) && !(tx_active_o && !mc[30]))
        else $error("direction outputs differ from direction bit");
    a_power_level: assert property (output_power_level_o == mc[14:12])
        else $error("output power level differs from field");
    a_freq_select: assert property (rx_freq_reg_o == mc[9:8] && tx_freq_reg_low_o == {mc[11], 1'b0})
        else $error("frequency register selection wrong");
    a_adc_route: assert property (adc_select_o == (!mc[24] ? 2'h0 : (mc[1] ? 2'h2 : 2'h1)))
        else $error("converter routing wrong");
    a_lock_gate: assert property (lock_lost_s |-> !tx_active_o)
        else $error("transmitting without lock");
    a_valid_rise: assert property ($rose(data_valid_o) |-> $past(adc_valid_i) && {1'b0, $past(adc_value_i)} >= $past(hi_lvl))
        else $error("validation rose without strong result");
    // A soft reset clears validation one cycle before power drops, so power must stay up one more cycle
    a_valid_fall: assert property ($fell(data_valid_o) && device_active_o && $past(device_active_o)
        ##1 device_active_o |-> $past(adc_valid_i, 2) && $past(lo_sum, 2) < {1'b0, $past(thr, 2)})
        else $error("validation fell without weak result");
    // Routing is registered on the same edge as the stored results; the comparison looks one cycle back
    a_strength_frozen: assert property ((adc_select_o != 2'h0) [*3] |->
        $past(measured_strength_o) == $past(measured_strength_o, 2))
        else $error("strength changed while not selected");
    a_supply_off: assert property (off_supply_s |-> $past(supply_level_o) == $past(supply_level_o, 2))
        else $error("supply result taken in power-down");
    a_valid_off: assert property (!device_active_o && !$past(device_active_o) |-> !data_valid_o)
        else $error("validation set in power-down");
endmodule

bind tmc_main_control tmc_mc_properties i_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .synth_lock_flag_i(synth_lock_flag_i),
    .adc_valid_i(adc_valid_i), .adc_value_i(adc_value_i), .device_active_o(device_active_o),
    .rx_active_o(rx_active_o), .tx_active_o(tx_active_o), .amplifier_active_o(amplifier_active_o),
    .output_power_level_o(output_power_level_o), .adc_select_o(adc_select_o),
    .tx_freq_reg_low_o(tx_freq_reg_low_o), .rx_freq_reg_o(rx_freq_reg_o), .data_valid_o(data_valid_o),
    .measured_strength_o(measured_strength_o), .supply_level_o(supply_level_o), .main_control_o(main_control_o));

// File: sim/tmc_host_model.sv
`timescale 1ns/1ps
module tmc_host_model (
    input  wire clock_i,
    input  wire sdata_i,
    output reg  sle_o,
    output reg  sck_o,
    output reg  sdata_o,
    output reg  sdata_oe_o
);
    initial begin
        sle_o = 1'b1;
        sck_o = 1'b0;
        sdata_o = 1'b0;
        sdata_oe_o = 1'b1;
    end
    // Six clocks per level leaves margin over the synchroniser delay
    task automatic half;
        repeat (6) @(posedge clock_i);
    endtask
    task automatic frame(input [3:0] addr, input wr, input [31:0] data, input int nbits, output [31:0] rdata);
        logic [4:0]  hdr;
        logic [31:0] d;
        hdr = {addr, wr};
        d = data & 32'hFFFFFBF2;
        rdata = 32'h0;
        @(posedge clock_i);
        sle_o <= 1'b0;
        half();
        for (int i = 0; i < 5 + nbits; i++) begin
            sck_o <= 1'b0;
            if (i < 5)
                sdata_o <= hdr[4 - i];
            else if (wr)
                sdata_o <= (i > 36) ? 1'b0 : d[36 - i];
            else
                sdata_oe_o <= 1'b0;
            half();
            if (i >= 5 && i <= 36)
                rdata[36 - i] = sdata_i;
            sck_o <= 1'b1;
            half();
        end
        sck_o <= 1'b0;
        half();
        sle_o <= 1'b1;
        sdata_oe_o <= 1'b1;
        repeat (8) @(posedge clock_i);
    endtask
endmodule

// File: sim/test_transceiver_main_control.sv
`timescale 1ns/1ps
`include "tmc_defines.vh"
module test_transceiver_main_control;
    reg          clock_i = 1'b0;
    reg          sys_rst_i = 1'b1;
    reg          lock = 1'b1;
    reg          adc_valid_i = 1'b0;
    reg  [5:0]   adc_value_i = 6'h00;
    reg          last_w = 1'b0;
    reg          rxd = 1'b0;
    wire         sle, sck, h_sd, h_oe, dut_sd, dut_oe, dev, rx, tx, amp, dvalid, dmd;
    wire [2:0]   lvl;
    wire [1:0]   adcsel, txl, rxf, txh;
    wire [6:0]   misc;
    wire [5:0]   strength, supply, disc;
    wire [31:0]  mc;
    // A released line shows the inverse of its last level, never a held value
    wire         sdata_w = dut_oe ? dut_sd : (h_oe ? h_sd : ~last_w);
    wire [19:0]  obs = {dev, rx, tx, amp, lvl, rxf, txl, adcsel, misc};
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [31:0] rd;
    logic [51:0] rows [9] = '{{32'hC8007000, 4'hB, 3'h7, 6'h00, 7'h00}, {32'h48003000, 4'h0, 3'h3, 6'h00, 7'h00},
        {32'h80000900, 4'hC, 3'h0, 6'h18, 7'h00}, {32'h80000A00, 4'hC, 3'h0, 6'h28, 7'h00},
        {32'h80000300, 4'hC, 3'h0, 6'h30, 7'h00}, {32'hA60000C0, 4'hC, 3'h0, 6'h00, 7'h7C},
        {32'hC1000002, 4'hA, 3'h0, 6'h02, 7'h00}, {32'hC1000000, 4'hA, 3'h0, 6'h01, 7'h00},
        {32'h20000000, 4'h0, 3'h0, 6'h00, 7'h00}};
    logic [6:0]  seq [10] = '{7'h1B, 7'h20, 7'h23, 7'h64, 7'h63, 7'h60, 7'h5D, 7'h5C, 7'h1B, 7'h19};
    localparam logic [19:0] RST_OBS = {4'h0, 3'h0, 6'h20, 7'h07};

    tmc_host_model i_host (.clock_i(clock_i), .sdata_i(sdata_w), .sle_o(sle), .sck_o(sck), .sdata_o(h_sd),
        .sdata_oe_o(h_oe));
    tmc_main_control i_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sle_i(sle), .sck_i(sck), .sdata_i(sdata_w),
        .sdata_o(dut_sd), .sdata_oe_o(dut_oe), .synth_lock_flag_i(lock), .rx_data_i(rxd),
        .adc_valid_i(adc_valid_i), .adc_value_i(adc_value_i), .device_active_o(dev), .rx_active_o(rx),
        .tx_active_o(tx), .amplifier_active_o(amp), .output_power_level_o(lvl),
        .recovered_clock_enable_o(misc[6]), .wakeup_enable_o(misc[5]), .input_gain_select_o(misc[4]),
        .adc_select_o(adcsel), .tx_freq_reg_low_o(txl), .tx_freq_reg_high_o(txh), .rx_freq_reg_o(rxf),
        .crystal_select_o(misc[3]), .discriminator_range_o(misc[2]), .data_polarity_o(misc[1]),
        .slicer_reference_select_o(misc[0]), .data_valid_o(dvalid), .demodulated_data_out_o(dmd),
        .measured_strength_o(strength), .supply_level_o(supply), .discriminator_level_o(disc),
        .main_control_o(mc));

    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) last_w <= sdata_w;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input [31:0] d, input int n);
        i_host.frame(4'h4, 1'b1, d, n, rd);
    endtask
    task automatic pulse(input [5:0] v);
        @(posedge clock_i);
        adc_valid_i <= 1'b1;
        adc_value_i <= v;
        @(posedge clock_i);
        adc_valid_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    initial begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        foreach (rows[i]) begin
            wr(rows[i][51:20], 32);
            check("outputs", obs, rows[i][19:0]);
            check("tx pair high", txh, {rows[i][31], 1'b1});
            i_host.frame(4'h4, 1'b0, 32'h0, 32, rd);
            check("readback", rd, rows[i][51:20] & `TMC_MC_WMASK);
        end
        $display("register rows done");
        lock <= 1'b0;
        wr(32'hD0000000, 32);
        check("tx gated", tx, 1'b0);
        lock <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("tx locked", tx, 1'b1);
        $display("lock gating done");
        wr(32'h80820000, 32);
        foreach (seq[i]) begin
            pulse(seq[i][5:0]);
            check("validation", dvalid, seq[i][6]);
            check("data out", dmd, seq[i][6]);
        end
        pulse(6'h24);
        // Inverted polarity: a high received level must show low while validated
        rxd <= 1'b1;
        repeat (4) @(posedge clock_i);
        check("data inverted", dmd, 1'b0);
        wr(32'hC1820000, 32);
        pulse(6'h32);
        check("supply", supply, 6'h32);
        check("strength held", strength, 6'h24);
        wr(32'h01820000, 32);
        check("valid off", dvalid, 1'b0);
        pulse(6'h0A);
        check("supply off", supply, 6'h32);
        wr(32'hC1820002, 32);
        pulse(6'h09);
        check("disc level", disc, 6'h09);
        check("valid after wake", dvalid, 1'b0);
        wr(32'h50000000, 4);
        check("partial write", mc, 32'h51820002);
        wr(32'h80820000, 33);
        check("long write", mc, 32'h80820000);
        $display("measurement tests done");
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check("hard reset", obs, RST_OBS);
        check("reset tx high", txh, 2'h1);
        check("reset value", mc, `TMC_MC_RESET);
        wr(32'hC8007000, 32);
        pulse(6'h11);
        i_host.frame(4'hB, 1'b1, 32'h0, 0, rd);
        check("soft reset", mc, `TMC_MC_RESET);
        check("soft reset outputs", obs, RST_OBS);
        check("results cleared", strength, 6'h00);
        i_host.frame(4'hC, 1'b0, 32'h0, 32, rd);
        check("unmapped read", rd, 32'hFFFFFFFF);
        $display("reset tests done");
        close_out();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        $display("watchdog expired");
        close_out();
    end
endmodule
